// File: pkg/mio_pkg.sv
// mixed i/o module logic: shared constants, states and config carriers
// assumes a 10 MHz core clock; all timing counts derive from it
package mio_pkg;
    localparam int NUM_DI = 16;
    localparam int NUM_RLY = 4;
    localparam int NUM_AI = 4;
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS = 1_000_000;
    localparam int FAST_STEP_NS = 25_000;
    localparam int MAINS50_PERIOD_NS = 10_000_000;
    localparam int MAINS60_PERIOD_NS = 8_330_000;
    localparam int MAINS_SUBS_LOG2 = 2;
    localparam int MAINS_SUBS = 1 << MAINS_SUBS_LOG2;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int FAST_CYCLES = FAST_STEP_NS / CLK_PERIOD_NS;
    localparam int SUB50_CYCLES = MAINS50_PERIOD_NS / (CLK_PERIOD_NS * MAINS_SUBS);
    localparam int SUB60_CYCLES = MAINS60_PERIOD_NS / (CLK_PERIOD_NS * MAINS_SUBS);
    localparam logic [3:0] RELAY_SETTLE_MS = 4'ha;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam int AVG_DEPTH_LOG2 = 7;
    localparam int EGU_FRAC_BITS = 8;

    typedef enum logic [1:0] {
        FAIL_OFF = 2'h0,
        FAIL_ON = 2'h1,
        FAIL_HOLD = 2'h2
    } mio_fail_t;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAKE = 3'b100
    } mio_state_t;

    typedef struct packed {
        logic [15:0] counterMode;
        logic [7:0] filterMs;
        logic [7:0] countFilter;
        logic [15:0] eventMask;
        logic [15:0] subst;
    } mio_di_cfg_t;

    typedef struct packed {
        logic mains60;
        logic [2:0] smoothLog2;
        logic eguSel;
        logic signed [15:0] gain;
        logic signed [15:0] offset;
        logic signed [15:0] lowLimit;
        logic signed [15:0] highLimit;
        logic signed [15:0] subst;
    } mio_ai_cfg_t;
endpackage : mio_pkg

// File: rtl/mio_di_filter.sv
// mixed i/o: one digital input debounce filter
// assumes a synchronised input and a one-cycle step tick
`timescale 1ns/1ns
`default_nettype none
module mio_di_filter (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic din,
    input wire logic tick,
    input wire logic [7:0] limit,
    input wire logic hold,
    output logic dout
);
    logic [7:0] cnt_q;

    // the input must stay changed for limit steps; zero passes it through
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 8'h00;
            dout <= 1'b0;
        end else if (hold) begin
            cnt_q <= 8'h00;
        end else if (din == dout) begin
            cnt_q <= 8'h00;
        end else if (limit == 8'h00) begin
            dout <= din;
        end else if (tick) begin
            if (cnt_q + 8'h01 >= limit) begin
                dout <= din;
                cnt_q <= 8'h00;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule : mio_di_filter
`default_nettype wire

// File: rtl/mio_ai_average.sv
// mixed i/o: running average over 2**log2N samples of one channel
// assumes log2N changes only together with a clear pulse
`timescale 1ns/1ns
`default_nettype none
module mio_ai_average (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clear,
    input wire logic inValid,
    input wire logic signed [15:0] inData,
    input wire logic [2:0] log2N,
    output logic outValid,
    output logic signed [15:0] outData
);
    logic signed [15:0] hist [0:127];
    logic [6:0] ptr_q;
    logic [7:0] fill_q;
    logic signed [23:0] sum_q;
    logic [7:0] depth;
    logic full;
    logic signed [15:0] oldest;
    logic signed [23:0] sumD;

    assign depth = 8'h01 << log2N;
    assign full = (fill_q == depth);
    assign oldest = hist[ptr_q - depth[6:0]];
    assign sumD = sum_q + 24'(inData) - (full ? 24'(oldest) : 24'sh000000);

    always_ff @(posedge core_clk) begin
        if (inValid) begin
            hist[ptr_q] <= inData;
        end
    end

    // until the window is filled the newest sample stands in for the mean
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ptr_q <= 7'h00;
            fill_q <= 8'h00;
            sum_q <= 24'sh000000;
            outValid <= 1'b0;
            outData <= 16'sh0000;
        end else if (clear) begin
            fill_q <= 8'h00;
            sum_q <= 24'sh000000;
            outValid <= 1'b0;
        end else begin
            outValid <= inValid;
            if (inValid) begin
                ptr_q <= ptr_q + 7'h01;
                sum_q <= sumD;
                if (!full) begin
                    fill_q <= fill_q + 8'h01;
                end
                if (full || fill_q + 8'h01 == depth) begin
                    outData <= 16'(sumD >>> log2N);
                end else begin
                    outData <= inData;
                end
            end
        end
    end
endmodule : mio_ai_average
`default_nettype wire

// File: rtl/mio_module_logic.sv
// mixed i/o module logic: 16 digital inputs, 4 relays, 4 analog inputs
// assumes converter samples on core_clk; pins are asynchronous
`timescale 1ns/1ns
`default_nettype none
// Function
// R1 - any digital input may count transitions up to 5 kHz
// R2 - each digital input can raise an event interrupt to the host
// R3 - relay command versus back indication mismatch is reported as fault
// R4 - inhibit open: energized relays drop to 0, latching relays hold
// R5 - while inhibited, relay position mismatches are not reported
// R6 - relay inhibit status is readable by the host
// R7 - analog results are 16-bit signed values
// R8 - analog samples pass a 50 or 60 Hz rejection filter, module-wide
// R9 - optional running average over a selectable sample count
// R10 - analog values shown raw or scaled to engineering units
// R11 - per input underflow and overflow flags while out of limits
// R12 - sleep stops the module; host sees substitute values
// R13 - module failure lights fault indicator and is host readable
// R14 - input debounce 0 to 255 ms in 1 ms steps
// R15 - counter input filter 0 to 6.375 ms in 0.025 ms steps
// R16 - input changes are time tagged in ms and interrupt
// R17 - on host failure each relay takes its configured fail state
// R18 - waking from sleep resumes without config reload
module mio_module_logic #(
    parameter int MS_CYC = mio_pkg::MS_CYCLES,
    parameter int SUB50_CYC = mio_pkg::SUB50_CYCLES,
    parameter int SUB60_CYC = mio_pkg::SUB60_CYCLES
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [15:0] digitalInputPin,
    input wire mio_pkg::mio_di_cfg_t diCfg,
    input wire logic [15:0] eventClear,
    output logic [15:0] diState,
    output logic [15:0][15:0] diCount,
    output logic [15:0] eventPending,
    output logic [15:0][15:0] eventTime,
    output logic eventIrq,
    input wire logic [3:0] relayCmd,
    input wire logic relayLatching,
    input wire logic [3:0][1:0] relayFailMode,
    input wire logic hostFail,
    input wire logic relayPowerInhibitInput,
    input wire logic [3:0] relayBackPin,
    output logic [3:0] relayDrive,
    output logic [3:0] relayMismatch,
    output logic relayInhibited,
    input wire mio_pkg::mio_ai_cfg_t aiCfg,
    output logic aiConvStart,
    input wire logic aiSampleValid,
    input wire logic [3:0][15:0] aiSample,
    input wire logic aiConvError,
    output logic [3:0][15:0] aiValue,
    output logic [3:0] underflowFlag,
    output logic [3:0] overflowFlag,
    input wire logic sleepReq,
    output logic sleeping,
    input wire logic faultClear,
    output logic moduleFault
);
    import mio_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and time base
    logic [20:0] pinMeta_q;
    logic [20:0] pinSync_q;
    logic [15:0] diSync;
    logic [3:0] backSync;
    logic powerOk;
    logic [13:0] msCnt_q;
    logic [7:0] fastCnt_q;
    logic msTick;
    logic fastTick;
    logic [15:0] msTime_q;
    mio_state_t state_q;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pinMeta_q <= 21'h000000;
            pinSync_q <= 21'h000000;
        end else begin
            pinMeta_q <= {relayPowerInhibitInput, relayBackPin, digitalInputPin};
            pinSync_q <= pinMeta_q;
        end
    end
    assign diSync = pinSync_q[15:0];
    assign backSync = pinSync_q[19:16];
    assign powerOk = pinSync_q[20];

    assign msTick = (msCnt_q == 14'(MS_CYC - 1));
    assign fastTick = (fastCnt_q == 8'(FAST_CYCLES - 1));
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            msCnt_q <= 14'h0000;
            fastCnt_q <= 8'h00;
            msTime_q <= 16'h0000;
        end else begin
            msCnt_q <= msTick ? 14'h0000 : msCnt_q + 14'h0001;
            fastCnt_q <= fastTick ? 8'h00 : fastCnt_q + 8'h01;
            if (msTick) begin
                msTime_q <= msTime_q + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sleep control: config ports are untouched, so waking needs no reload
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_RUN;
        end else begin
            case (state_q)
                ST_RUN: state_q <= sleepReq ? ST_SLEEP : ST_RUN; // [R12]
                ST_SLEEP: state_q <= sleepReq ? ST_SLEEP : ST_WAKE;
                ST_WAKE: state_q <= ST_RUN; // [R18]
                default: state_q <= ST_RUN;
            endcase
        end
    end
    assign sleeping = (state_q == ST_SLEEP);

    ////////////////////////////////////////////////////////////////////////
    // digital inputs: filter, count, events
    logic [15:0] filt;
    logic [15:0] filtPrev_q;
    logic [15:0] diChange;
    logic [15:0] filtRise;

    for (genvar i = 0; i < NUM_DI; i++) begin : g_di
        mio_di_filter u_filt (
            .core_clk(core_clk),
            .resetn(resetn),
            .din(diSync[i]),
            .tick(diCfg.counterMode[i] ? fastTick : msTick), // [R14] [R15]
            .limit(diCfg.counterMode[i] ? diCfg.countFilter : diCfg.filterMs),
            .hold(sleeping),
            .dout(filt[i])
        );

        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                diCount[i] <= COUNT_RESET;
            end else if (filtRise[i] && diCfg.counterMode[i]) begin
                diCount[i] <= diCount[i] + 16'h0001; // [R1]
            end
        end

        // a change in the same cycle as its clear stays pending
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                eventPending[i] <= 1'b0;
                eventTime[i] <= 16'h0000;
            end else if (diChange[i]) begin
                eventPending[i] <= 1'b1; // [R2]
                eventTime[i] <= msTime_q; // [R16]
            end else if (eventClear[i]) begin
                eventPending[i] <= 1'b0;
            end
        end
    end

    assign diChange = (filt ^ filtPrev_q) & {16{!sleeping}};
    assign filtRise = filt & ~filtPrev_q & {16{!sleeping}};
    assign eventIrq = |(eventPending & diCfg.eventMask); // [R2] [R16]

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            filtPrev_q <= 16'h0000;
            diState <= 16'h0000;
        end else begin
            filtPrev_q <= filt;
            diState <= sleeping ? diCfg.subst : filt; // [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // relays
    logic [3:0] settleCnt_q;
    logic settled;

    assign settled = (settleCnt_q == RELAY_SETTLE_MS);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            relayDrive <= 4'h0;
        end else begin
            for (int r = 0; r < NUM_RLY; r++) begin
                if (relayInhibited || sleeping) begin
                    relayDrive[r] <= relayLatching & relayDrive[r]; // [R4]
                end else if (hostFail) begin
                    case (mio_fail_t'(relayFailMode[r]))
                        FAIL_ON: relayDrive[r] <= 1'b1; // [R17]
                        FAIL_OFF: relayDrive[r] <= 1'b0; // [R17]
                        default: relayDrive[r] <= relayDrive[r];
                    endcase
                end else begin
                    relayDrive[r] <= relayCmd[r];
                end
            end
        end
    end

    // contacts need time to move, so compare only after the drive rests
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            settleCnt_q <= 4'h0;
            relayMismatch <= 4'h0;
            relayInhibited <= 1'b1;
        end else begin
            relayInhibited <= !powerOk; // [R6]
            if (relayDrive != $past(relayDrive)) begin
                settleCnt_q <= 4'h0;
            end else if (msTick && !settled) begin
                settleCnt_q <= settleCnt_q + 4'h1;
            end
            if (relayInhibited || sleeping || !settled) begin
                relayMismatch <= 4'h0; // [R5]
            end else begin
                relayMismatch <= relayDrive ^ backSync; // [R3]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // analog inputs: quarter-cycle subsamples averaged over one mains period
    logic [16:0] subCnt_q;
    logic [1:0] subIdx_q;
    logic takeQ;
    logic avgClear;
    logic [3:0] mainsValid;
    logic [3:0][15:0] mainsOut;
    logic [3:0] smoothValid;
    logic [3:0][15:0] smoothOut;
    logic mains60Prev_q;
    logic [2:0] smoothPrev_q;

    assign aiConvStart = (subCnt_q == 17'h00000) && !sleeping;
    assign avgClear = (state_q == ST_WAKE) || (mains60Prev_q != aiCfg.mains60)
        || (smoothPrev_q != aiCfg.smoothLog2);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            subCnt_q <= 17'h00000;
            subIdx_q <= 2'h0;
            takeQ <= 1'b0;
            mains60Prev_q <= 1'b0;
            smoothPrev_q <= 3'h0;
        end else begin
            mains60Prev_q <= aiCfg.mains60;
            smoothPrev_q <= aiCfg.smoothLog2;
            // >= so a switch to the shorter 60 Hz period cannot leave the count past its end
            if (sleeping || subCnt_q >= 17'(aiCfg.mains60 ? SUB60_CYC - 1 : SUB50_CYC - 1)) begin
                subCnt_q <= 17'h00000; // [R8]
            end else begin
                subCnt_q <= subCnt_q + 17'h00001;
            end
            takeQ <= aiSampleValid && (subIdx_q == 2'(MAINS_SUBS - 1));
            if (avgClear) begin
                subIdx_q <= 2'h0;
            end else if (aiSampleValid) begin
                subIdx_q <= subIdx_q + 2'h1;
            end
        end
    end

    for (genvar c = 0; c < NUM_AI; c++) begin : g_ai
        logic signed [31:0] scaled;

        mio_ai_average u_mains (
            .core_clk(core_clk),
            .resetn(resetn),
            .clear(avgClear),
            .inValid(aiSampleValid && !sleeping),
            .inData(aiSample[c]), // [R7]
            .log2N(3'(MAINS_SUBS_LOG2)), // [R8]
            .outValid(mainsValid[c]),
            .outData(mainsOut[c])
        );
        mio_ai_average u_smooth (
            .core_clk(core_clk),
            .resetn(resetn),
            .clear(avgClear),
            .inValid(mainsValid[c] && takeQ),
            .inData(mainsOut[c]),
            .log2N(aiCfg.smoothLog2), // [R9]
            .outValid(smoothValid[c]),
            .outData(smoothOut[c])
        );

        // scaled result wraps rather than saturates; keep gain in range
        assign scaled = ((32'(signed'(smoothOut[c])) * 32'(aiCfg.gain)) >>> EGU_FRAC_BITS)
            + 32'(aiCfg.offset);

        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                aiValue[c] <= 16'h0000;
                underflowFlag[c] <= 1'b0;
                overflowFlag[c] <= 1'b0;
            end else if (sleeping) begin
                aiValue[c] <= aiCfg.subst; // [R12]
                underflowFlag[c] <= 1'b0;
                overflowFlag[c] <= 1'b0;
            end else if (smoothValid[c]) begin
                aiValue[c] <= aiCfg.eguSel ? scaled[15:0] : smoothOut[c]; // [R10]
                underflowFlag[c] <= signed'(smoothOut[c]) < aiCfg.lowLimit; // [R11]
                overflowFlag[c] <= signed'(smoothOut[c]) > aiCfg.highLimit; // [R11]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // module fault: sticky, a new error beats a clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            moduleFault <= 1'b0;
        end else if (aiConvError) begin
            moduleFault <= 1'b1; // [R13]
        end else if (faultClear) begin
            moduleFault <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    property p_count_edge;
        filtRise[0] && diCfg.counterMode[0] |=> diCount[0] == $past(diCount[0]) + 16'h0001;
    endproperty
    a_count_edge: assert property (p_count_edge) else $error("count missed"); // [R1]

    property p_event_tag;
        diChange[3] |=> eventPending[3] && eventTime[3] == $past(msTime_q);
    endproperty
    a_event_tag: assert property (p_event_tag) else $error("event not tagged"); // [R16]

    property p_irq;
        eventPending[3] && diCfg.eventMask[3] |-> eventIrq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised"); // [R2]

    property p_mismatch_cause;
        relayMismatch[1] |-> $past(relayDrive[1] != backSync[1]) && $past(settled);
    endproperty
    a_mismatch_cause: assert property (p_mismatch_cause) else $error("bad mismatch"); // [R3]

    property p_inhibit_ee;
        relayInhibited && !relayLatching |=> relayDrive == 4'h0;
    endproperty
    a_inhibit_ee: assert property (p_inhibit_ee) else $error("relay not dropped"); // [R4]

    property p_inhibit_ml;
        relayInhibited && relayLatching |=> $stable(relayDrive);
    endproperty
    a_inhibit_ml: assert property (p_inhibit_ml) else $error("latch moved"); // [R4]

    property p_inhibit_quiet;
        relayInhibited |=> relayMismatch == 4'h0;
    endproperty
    a_inhibit_quiet: assert property (p_inhibit_quiet) else $error("mismatch shown"); // [R5]

    property p_inhibit_status;
        $fell(powerOk) |=> relayInhibited [*2];
    endproperty
    a_inhibit_status: assert property (p_inhibit_status) else $error("status late"); // [R6]

    property p_sleep_subst;
        sleeping |=> diState == $past(diCfg.subst) && aiValue[0] == $past(aiCfg.subst);
    endproperty
    a_sleep_subst: assert property (p_sleep_subst) else $error("no substitute"); // [R12]

    property p_fault_hold;
        moduleFault && !faultClear |=> moduleFault;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault lost"); // [R13]

    property p_fail_off;
        hostFail && !relayInhibited && !sleeping && relayFailMode[0] == FAIL_OFF
            |=> !relayDrive[0];
    endproperty
    a_fail_off: assert property (p_fail_off) else $error("fail state"); // [R17]

    property p_wake;
        sleeping && !sleepReq |=> state_q == ST_WAKE ##1 state_q == ST_RUN;
    endproperty
    a_wake: assert property (p_wake) else $error("wake path"); // [R18]

    c_irq: cover property (eventIrq);
    c_inhibit: cover property (relayInhibited ##1 !relayInhibited);
    c_wake: cover property (state_q == ST_WAKE);
    c_mismatch: cover property (|relayMismatch);
endmodule : mio_module_logic
`default_nettype wire

// File: tb/mio_adc_model.sv
// converter model: answers each start pulse with four signed samples
// assumes the bench sets the analog level and the error request
`timescale 1ns/1ns
`default_nettype none
module mio_adc_model #(
    parameter int LAT = 5
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic aiConvStart,
    input wire logic [15:0] level,
    input wire logic errInject,
    output logic aiSampleValid,
    output logic [3:0][15:0] aiSample,
    output logic aiConvError
);
    logic [7:0] cnt_q;
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 8'h00;
            aiSampleValid <= 1'b0;
            aiConvError <= 1'b0;
            aiSample <= '0;
        end else begin
            aiSampleValid <= 1'b0;
            aiConvError <= 1'b0;
            // data is only valid with the strobe; scramble it otherwise
            if (aiSampleValid) begin
                aiSample <= ~aiSample;
            end
            if (aiConvStart) begin
                cnt_q <= 8'(LAT);
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    aiSampleValid <= 1'b1;
                    aiConvError <= errInject;
                    aiSample <= {4{level}};
                end
            end
        end
    end
endmodule : mio_adc_model
`default_nettype wire

// File: tb/mio_module_logic_tb.sv
// bench for the mixed i/o module logic with a converter model
// assumes shortened ms and mains counts set by parameters below
`timescale 1ns/1ns
`default_nettype none
module mio_module_logic_tb;
    import mio_pkg::*;
    logic core_clk, resetn, eventIrq, relayLatching, hostFail, relayPowerInhibitInput;
    logic aiConvStart, aiSampleValid, aiConvError, sleepReq, sleeping, faultClear;
    logic moduleFault, relayInhibited, errInject;
    logic [15:0] digitalInputPin, eventClear, diState, eventPending, level;
    logic [15:0][15:0] diCount, eventTime;
    logic [3:0] relayCmd, relayBackPin, relayDrive, relayMismatch, underflowFlag, overflowFlag;
    logic [3:0][1:0] relayFailMode;
    logic [3:0][15:0] aiSample, aiValue;
    mio_di_cfg_t diCfg;
    mio_ai_cfg_t aiCfg;
    int nFail = 0;
    int checksDone = 0;
    int p;
    ////////////////////////////////////////////////////////////////
    mio_module_logic #(.MS_CYC(20), .SUB50_CYC(40), .SUB60_CYC(33)) i_dut (.core_clk(core_clk),
        .resetn(resetn), .digitalInputPin(digitalInputPin), .diCfg(diCfg),
        .eventClear(eventClear), .diState(diState), .diCount(diCount),
        .eventPending(eventPending), .eventTime(eventTime), .eventIrq(eventIrq),
        .relayCmd(relayCmd), .relayLatching(relayLatching), .relayFailMode(relayFailMode),
        .hostFail(hostFail), .relayPowerInhibitInput(relayPowerInhibitInput),
        .relayBackPin(relayBackPin), .relayDrive(relayDrive), .relayMismatch(relayMismatch),
        .relayInhibited(relayInhibited), .aiCfg(aiCfg), .aiConvStart(aiConvStart),
        .aiSampleValid(aiSampleValid), .aiSample(aiSample), .aiConvError(aiConvError),
        .aiValue(aiValue), .underflowFlag(underflowFlag), .overflowFlag(overflowFlag),
        .sleepReq(sleepReq), .sleeping(sleeping), .faultClear(faultClear),
        .moduleFault(moduleFault));
    mio_adc_model i_adc (.core_clk(core_clk), .resetn(resetn), .aiConvStart(aiConvStart),
        .level(level), .errInject(errInject), .aiSampleValid(aiSampleValid),
        .aiSample(aiSample), .aiConvError(aiConvError));
    ////////////////////////////////////////////////////////////////
    task automatic w(input int n);
        repeat (n) @(negedge core_clk);
    endtask : w
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nFail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // cycles between two start pulses, bounded so a dead converter path cannot hang
    task automatic period(output int n);
        int t;
        t = 0;
        while (aiConvStart !== 1'b1 && t < 200) begin
            w(1);
            t++;
        end
        w(1);
        n = 1;
        while (aiConvStart !== 1'b1 && n < 200) begin
            w(1);
            n++;
        end
    endtask : period
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        #(100 * 20000);
        nFail++;
        report_and_stop();
    end
    initial begin
        {resetn, digitalInputPin, eventClear, relayCmd, relayLatching, hostFail} = '0;
        {relayBackPin, errInject, sleepReq, faultClear, relayFailMode} = '0;
        relayPowerInhibitInput = 1'b1;
        level = 16'h0064;
        diCfg = '{16'h0001, 8'h00, 8'h00, 16'h0001, 16'h00f0};
        aiCfg = '{1'b0, 3'h0, 1'b0, 16'h0100, 16'h0000, 16'hff9c, 16'h7f00, 16'h1234};
        w(4);
        chk("inhibited in reset", relayInhibited, 1'b1);
        w(4);
        resetn = 1'b1;
        w(5);
        digitalInputPin[0] = 1'b1;
        w(10);
        chk("diState", diState, 16'h0001);
        chk("eventIrq", eventIrq, 1'b1);
        for (int i = 0; i < 3; i++) begin
            digitalInputPin[0] = 1'b0;
            w(10);
            digitalInputPin[0] = 1'b1;
            w(10);
        end
        chk("diCount0", diCount[0], 16'h0004);
        eventClear = 16'hffff;
        w(2);
        eventClear = 16'h0000;
        w(1);
        chk("pending cleared", eventPending, 16'h0000);
        digitalInputPin[2] = 1'b1;
        w(10);
        chk("pending2", eventPending, 16'h0004);
        chk("masked irq", eventIrq, 1'b0);
        diCfg.filterMs = 8'h02;
        digitalInputPin[1] = 1'b1;
        w(10);
        digitalInputPin[1] = 1'b0;
        w(60);
        chk("short pulse", diState[1], 1'b0);
        digitalInputPin[1] = 1'b1;
        w(80);
        chk("long pulse", diState[1], 1'b1);
        relayCmd = 4'h5;
        relayBackPin = 4'h5;
        w(300);
        chk("drive", relayDrive, 4'h5);
        chk("no mismatch", relayMismatch, 4'h0);
        relayBackPin = 4'h4;
        w(10);
        chk("mismatch", relayMismatch, 4'h1);
        relayFailMode = {2'h2, 2'h2, 2'h1, 2'h0};
        hostFail = 1'b1;
        w(3);
        chk("fail state", relayDrive, 4'h6);
        hostFail = 1'b0;
        relayPowerInhibitInput = 1'b0;
        w(300);
        chk("inhibit status", relayInhibited, 1'b1);
        chk("energized drop", relayDrive, 4'h0);
        chk("mismatch hidden", relayMismatch, 4'h0);
        relayPowerInhibitInput = 1'b1;
        relayLatching = 1'b1;
        w(5);
        relayPowerInhibitInput = 1'b0;
        w(5);
        relayCmd = 4'ha;
        w(5);
        chk("latching hold", relayDrive, 4'h5);
        relayPowerInhibitInput = 1'b1;
        relayLatching = 1'b0;
        period(p);
        chk("50 Hz period", 64'(p), 64'd40);
        w(400);
        chk("aiValue raw", aiValue, {4{16'h0064}});
        chk("no underflow", underflowFlag, 4'h0);
        aiCfg.lowLimit = 16'h00c8;
        w(400);
        chk("underflow", underflowFlag, 4'hf);
        aiCfg = '{1'b0, 3'h0, 1'b1, 16'h0200, 16'h0005, 16'hff9c, 16'h0050, 16'h1234};
        w(400);
        chk("aiValue egu", aiValue, {4{16'h00cd}});
        chk("overflow", overflowFlag, 4'hf);
        aiCfg.mains60 = 1'b1;
        period(p);
        chk("60 Hz period", 64'(p), 64'd33);
        errInject = 1'b1;
        w(100);
        errInject = 1'b0;
        chk("fault", moduleFault, 1'b1);
        faultClear = 1'b1;
        w(2);
        faultClear = 1'b0;
        w(2);
        chk("fault cleared", moduleFault, 1'b0);
        sleepReq = 1'b1;
        w(5);
        chk("sleeping", sleeping, 1'b1);
        chk("di subst", diState, 16'h00f0);
        chk("ai subst", aiValue, {4{16'h1234}});
        sleepReq = 1'b0;
        w(10);
        chk("di awake", diState, 16'h0007);
        chk("relay awake", relayDrive, 4'ha);
        report_and_stop();
    end
endmodule : mio_module_logic_tb
`default_nettype wire
